// File: hdl/aslp_dev.sv
// Purpose: sensor end of the single line programming link
// Assumes: line sampled synchronously; master uses the shared bit period
// Notes: command mode is left only by reset
`timescale 1ns/100ps
module aslp_dev
#(
    parameter logic [15:0] TIMEOUT_CYC = aslp_pkg::TO_CYC,
    parameter logic [23:0] TON_CYC = aslp_pkg::TON_CYC,
    parameter logic [23:0] ENTRY_CYC = aslp_pkg::ENTRY_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    aslp_link_if.dev link,
    input wire logic norm_out,
    input wire logic [15:0] rd_data,
    output logic normal_run,
    output logic cmd_mode,
    output logic wr_valid,
    output logic [6:0] wr_addr,
    output logic [15:0] wr_data,
    output logic rd_req,
    output logic [6:0] rd_addr,
    output logic link_timeout
);
    import aslp_pkg::*;

    aslp_dev_state_type st_q;
    logic line_q;
    logic [15:0] per_q;
    logic [15:0] hi_q;
    logic [15:0] tc_q;
    logic [15:0] txw_q;
    logic [23:0] sr_q;
    logic [23:0] life_q;
    logic [4:0] nb_q;
    logic [4:0] tb_q;
    logic tk_q, slot_q, hi_ok_q, cmd_q, normal_q, to_q;
    logic wr_q, rdq_q;
    logic [6:0] wa_q;
    logic [6:0] ra_q;
    logic [15:0] wd_q;
    logic dev_o_q, dev_oe_q;
    logic rise, fall, to_evt, bit_val, link_on, wr_done, rd_go, tx_end, tx_lvl;

    // Edge and event decode
    assign rise = link.line & ~line_q;
    assign fall = ~link.line & line_q;
    assign to_evt = (per_q == TIMEOUT_CYC - 16'h0001) & ~rise;
    assign bit_val = aslp_is_one(hi_q, per_q);
    assign link_on = cmd_q | slot_q;
    // The stop rise closes the last data bit, so the frame ends on that rise
    assign wr_done = (st_q == D_RX) & rise & (nb_q == NB_WR_LAST);
    assign rd_go = (st_q == D_RX) & rise & (nb_q == NB_CMD_LAST) & bit_val & cmd_q;
    assign tx_end = ~tk_q & (tb_q == 5'h10) & (tc_q == ONE_CYC - 16'h0001);
    assign tx_lvl = ~tk_q & (tc_q < (txw_q[15] ? ONE_CYC : ZERO_CYC));

    // Period and high time since the last rise; period saturates at the timeout
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // Idle level is high; a low reset value would fake a rise after reset
            line_q <= 1'b1;
            per_q <= 16'h0000;
            hi_q <= 16'h0000;
        end
        else
        begin
            line_q <= link.line;
            if (rise)
            begin
                per_q <= 16'h0001;
                hi_q <= 16'h0001;
            end
            else
            begin
                if (per_q != TIMEOUT_CYC)
                    per_q <= per_q + 16'h0001;
                if (link.line && hi_q != 16'hFFFF)
                    hi_q <= hi_q + 16'h0001;
            end
        end
    end

    // Frame sequencer; the sensor never starts a frame on its own
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_q <= D_IDLE;
            nb_q <= 5'h00;
            sr_q <= 24'h00_0000;
        end
        else if (to_evt)
            st_q <= D_IDLE;
        else
        begin
            unique case (st_q)
                D_IDLE:
                    if (rise && link_on)
                    begin
                        st_q <= D_RX;
                        nb_q <= 5'h00;
                    end
                D_RX:
                    if (rise)
                    begin
                        nb_q <= nb_q + 5'h01;
                        sr_q <= {sr_q[22:0], bit_val};
                        if (nb_q == NB_WR_LAST)
                            st_q <= D_IDLE;
                        // Reads outside command mode are dropped
                        else if (nb_q == NB_CMD_LAST && bit_val)
                            st_q <= cmd_q ? D_HND : D_IDLE;
                    end
                D_HND:
                    if (fall)
                        st_q <= D_TX;
                D_TX:
                    if (tx_end)
                        st_q <= D_REL;
                D_REL:
                    if (rise)
                        st_q <= D_IDLE;
                default:
                    st_q <= D_IDLE;
            endcase
        end
    end

    // Read data transmitter: takeover low, 16 bits MSB first, then a zero handover bit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tc_q <= 16'h0000;
            tb_q <= 5'h00;
            tk_q <= 1'b0;
            txw_q <= 16'h0000;
        end
        else if (st_q == D_HND && fall)
        begin
            tc_q <= 16'h0000;
            tb_q <= 5'h00;
            tk_q <= 1'b1;
            txw_q <= rd_data;
        end
        else if (st_q == D_TX)
        begin
            if (tk_q)
            begin
                if (tc_q == SLV_LOW_CYC - 16'h0001)
                begin
                    tk_q <= 1'b0;
                    tc_q <= 16'h0000;
                end
                else
                    tc_q <= tc_q + 16'h0001;
            end
            else if (tc_q == BIT_CYC - 16'h0001)
            begin
                // Zeros shifted in form the closing handover bit
                tc_q <= 16'h0000;
                tb_q <= tb_q + 5'h01;
                txw_q <= {txw_q[14:0], 1'b0};
            end
            else
                tc_q <= tc_q + 16'h0001;
        end
    end

    // Pin driver: normal output until command mode, then only while sending
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dev_oe_q <= 1'b1;
            dev_o_q <= 1'b0;
        end
        else
        begin
            dev_oe_q <= ~cmd_q | (st_q == D_TX);
            dev_o_q <= (st_q == D_TX) ? tx_lvl : norm_out;
        end
    end

    // Power-on timing, entry slot and sticky command mode
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            life_q <= 24'h00_0000;
            slot_q <= 1'b1;
            hi_ok_q <= 1'b0;
            cmd_q <= 1'b0;
            normal_q <= 1'b0;
        end
        else
        begin
            if (life_q != 24'hFF_FFFF)
                life_q <= life_q + 24'h00_0001;
            if (life_q == ENTRY_CYC)
                slot_q <= 1'b0;
            if (to_evt && link.line)
                hi_ok_q <= 1'b1;
            // Never cleared except by reset
            if (wr_done && slot_q && hi_ok_q)
                cmd_q <= 1'b1;
            normal_q <= (life_q >= TON_CYC) & ~cmd_q;
        end
    end

    // User side strobes for memory and register access
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_q <= 1'b0;
            wa_q <= 7'h00;
            wd_q <= 16'h0000;
            rdq_q <= 1'b0;
            ra_q <= 7'h00;
            to_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_done & (cmd_q | (slot_q & hi_ok_q));
            if (wr_done)
            begin
                // Last data bit is still on bit_val at the closing rise
                wa_q <= sr_q[22:16];
                wd_q <= {sr_q[14:0], bit_val};
            end
            rdq_q <= rd_go;
            if (rd_go)
                ra_q <= sr_q[6:0];
            to_q <= to_evt & (st_q != D_IDLE);
        end
    end

    assign link.dev_o = dev_o_q;
    assign link.dev_oe = dev_oe_q;
    assign normal_run = normal_q;
    assign cmd_mode = cmd_q;
    assign wr_valid = wr_q;
    assign wr_addr = wa_q;
    assign wr_data = wd_q;
    assign rd_req = rdq_q;
    assign rd_addr = ra_q;
    assign link_timeout = to_q;
endmodule

// File: hdl/aslp_host.sv
// Purpose: programming master end with a command queue
// Assumes: line sampled synchronously; sensor uses the shared bit period
// Notes: checksum upkeep is left to software feeding the queue
`timescale 1ns/100ps
module aslp_fifo
#(
    parameter int W = 24,
    parameter int D = 8
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic rdy_q, push, pop;

    assign push = in_valid & rdy_q;
    assign pop = (cnt_q != '0) & out_ready;
    assign cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));

    // Pointers and fill count; ready is registered so it never loops back combinationally
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(D - 1)) ? '0 : AW'(wp_q + 1'b1);
            if (pop)
                rp_q <= (rp_q == AW'(D - 1)) ? '0 : AW'(rp_q + 1'b1);
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != CW'(D);
        end
    end

    // Storage
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end

    assign in_ready = rdy_q;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
endmodule

module aslp_host
#(
    parameter logic [15:0] TIMEOUT_CYC = aslp_pkg::TO_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    aslp_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [6:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic busy,
    output logic link_timeout
);
    import aslp_pkg::*;

    aslp_host_state_type st_q;
    logic [CMD_W-1:0] f_data;
    logic f_valid, f_pop;
    logic line_q, rise, fall, to_evt, bit_val, tx_lvl;
    logic [15:0] per_q;
    logic [15:0] hi_q;
    logic [15:0] tc_q;
    logic [15:0] rx_q;
    logic [15:0] rdd_q;
    logic [23:0] sh_q;
    logic [4:0] nb_q;
    logic rd_cmd_q, host_o_q, host_oe_q, rdv_q, busy_q, to_q;

    // Commands wait here while a frame is on the line
    aslp_fifo #(.W(CMD_W), .D(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_read, cmd_addr, cmd_data}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    // Edge and event decode
    assign f_pop = (st_q == H_IDLE) & f_valid;
    assign rise = link.line & ~line_q;
    assign fall = ~link.line & line_q;
    assign to_evt = (per_q == TIMEOUT_CYC - 16'h0001) & ~rise;
    assign bit_val = aslp_is_one(hi_q, per_q);
    assign tx_lvl = tc_q < (sh_q[23] ? ONE_CYC : ZERO_CYC);

    // Period and high time since the last rise
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // Idle level is high, so no false rise follows reset
            line_q <= 1'b1;
            per_q <= 16'h0000;
            hi_q <= 16'h0000;
        end
        else
        begin
            line_q <= link.line;
            if (rise)
            begin
                per_q <= 16'h0001;
                hi_q <= 16'h0001;
            end
            else
            begin
                if (per_q != TIMEOUT_CYC)
                    per_q <= per_q + 16'h0001;
                if (link.line && hi_q != 16'hFFFF)
                    hi_q <= hi_q + 16'h0001;
            end
        end
    end

    // Frame sequencer
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_q <= H_PRE;
            tc_q <= 16'h0000;
            nb_q <= 5'h00;
            sh_q <= 24'h00_0000;
            rx_q <= 16'h0000;
            rd_cmd_q <= 1'b0;
        end
        else
        begin
            unique case (st_q)
                H_PRE:
                    if (tc_q == TIMEOUT_CYC - 16'h0001)
                    begin
                        st_q <= H_IDLE;
                        tc_q <= 16'h0000;
                    end
                    else
                        tc_q <= tc_q + 16'h0001;
                H_IDLE:
                    if (f_valid)
                    begin
                        st_q <= H_START;
                        tc_q <= 16'h0000;
                        nb_q <= 5'h00;
                        rd_cmd_q <= f_data[23];
                        // Read frames send a zero handover bit after the command
                        sh_q <= {f_data[22:16], f_data[23],
                            f_data[23] ? 16'h0000 : f_data[15:0]};
                    end
                H_START:
                    if (tc_q == START_CYC - 16'h0001)
                    begin
                        st_q <= H_TXB;
                        tc_q <= 16'h0000;
                    end
                    else
                        tc_q <= tc_q + 16'h0001;
                H_TXB:
                    if (rd_cmd_q && nb_q == NB_HOV && tc_q == ONE_CYC - 16'h0001)
                    begin
                        st_q <= H_RX;
                        nb_q <= 5'h00;
                    end
                    else if (tc_q == BIT_CYC - 16'h0001)
                    begin
                        tc_q <= 16'h0000;
                        nb_q <= nb_q + 5'h01;
                        sh_q <= {sh_q[22:0], 1'b0};
                        if (!rd_cmd_q && nb_q == NB_WR_LAST)
                            st_q <= H_STOP;
                    end
                    else
                        tc_q <= tc_q + 16'h0001;
                H_RX:
                    if (to_evt)
                        st_q <= H_IDLE;
                    else if (rise)
                    begin
                        // First rise only opens bit 0; later rises close one bit each
                        nb_q <= nb_q + 5'h01;
                        if (nb_q != 5'h00)
                            rx_q <= {rx_q[14:0], bit_val};
                    end
                    else if (fall && nb_q == NB_RX_END)
                    begin
                        st_q <= H_MTKO;
                        tc_q <= 16'h0000;
                    end
                H_MTKO:
                    if (tc_q == MAS_LOW_CYC - 16'h0001)
                    begin
                        st_q <= H_STOP;
                        tc_q <= 16'h0000;
                    end
                    else
                        tc_q <= tc_q + 16'h0001;
                H_STOP:
                    if (tc_q == STOP_CYC - 16'h0001)
                    begin
                        st_q <= H_IDLE;
                        tc_q <= 16'h0000;
                    end
                    else
                        tc_q <= tc_q + 16'h0001;
                default:
                    st_q <= H_IDLE;
            endcase
        end
    end

    // Line driver; driving high at idle also overdrives the sensor buffer
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            host_oe_q <= 1'b1;
            host_o_q <= 1'b1;
        end
        else
        begin
            unique case (st_q)
                H_PRE, H_IDLE, H_STOP:
                begin
                    host_oe_q <= 1'b1;
                    host_o_q <= 1'b1;
                end
                H_START, H_MTKO:
                begin
                    host_oe_q <= 1'b1;
                    host_o_q <= 1'b0;
                end
                H_TXB:
                begin
                    host_oe_q <= 1'b1;
                    host_o_q <= tx_lvl;
                end
                default:
                begin
                    host_oe_q <= 1'b0;
                    host_o_q <= 1'b0;
                end
            endcase
        end
    end

    // User side results
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdv_q <= 1'b0;
            rdd_q <= 16'h0000;
            busy_q <= 1'b1;
            to_q <= 1'b0;
        end
        else
        begin
            rdv_q <= (st_q == H_MTKO) & (tc_q == MAS_LOW_CYC - 16'h0001);
            if (st_q == H_MTKO)
                rdd_q <= rx_q;
            busy_q <= st_q != H_IDLE;
            to_q <= (st_q == H_RX) & to_evt;
        end
    end

    assign link.host_o = host_o_q;
    assign link.host_oe = host_oe_q;
    assign rd_valid = rdv_q;
    assign rd_data = rdd_q;
    assign busy = busy_q;
    assign link_timeout = to_q;
endmodule

// File: hdl/aslp_link_if.sv
// Purpose: the shared data line between programming master and sensor
// Assumes: a pull-up holds the line high when nobody drives
// Notes: the master overdrives the sensor buffer when both drive
`timescale 1ns/100ps
interface aslp_link_if;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic line;

    // Wire level resolved from the enables, master wins a conflict
    assign line = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);

    modport host (output host_o, output host_oe, input line);
    modport dev (output dev_o, output dev_oe, input line);
endinterface

// File: hdl/aslp_pkg.sv
// Purpose: shared constants, states and bit decode for the single line programming link
// Assumes: both ends run on the same 40 MHz system clock
// Notes: bit period is fixed at build time and both ends use the same value
package aslp_pkg;
    // System clock rate
    localparam logic [23:0] CLK_MHZ = 24'h00_0028;
    // Times in microseconds
    localparam logic [15:0] T_START_US = 16'h0005;
    localparam logic [15:0] T_STOP_US = 16'h0005;
    localparam logic [15:0] T_BIT_US = 16'h0014;
    localparam logic [15:0] T_TKO_SLV_US = 16'h0002;
    localparam logic [15:0] T_TO_US = 16'h00FA;
    localparam logic [23:0] T_ON_US = 24'h00_03E8;
    localparam logic [23:0] T_ENTRY_US = 24'h00_61A8;
    // Cycle counts derived from the times
    localparam logic [15:0] START_CYC = 16'(T_START_US * CLK_MHZ);
    localparam logic [15:0] STOP_CYC = 16'(T_STOP_US * CLK_MHZ);
    localparam logic [15:0] BIT_CYC = 16'(T_BIT_US * CLK_MHZ);
    localparam logic [15:0] ONE_CYC = 16'((BIT_CYC * 16'h0003) / 16'h0004);
    localparam logic [15:0] ZERO_CYC = 16'(BIT_CYC / 16'h0004);
    localparam logic [15:0] TKO_SLV_CYC = 16'(T_TKO_SLV_US * CLK_MHZ);
    localparam logic [15:0] TO_CYC = 16'(T_TO_US * CLK_MHZ);
    localparam logic [23:0] TON_CYC = 24'(T_ON_US * CLK_MHZ);
    localparam logic [23:0] ENTRY_CYC = 24'(T_ENTRY_US * CLK_MHZ);
    // Slave low after the handover fall: master still drives low until 3/4 bit
    localparam logic [15:0] SLV_LOW_CYC = 16'((BIT_CYC >> 1) + TKO_SLV_CYC);
    // Master low after the slave handover fall, ends past the slave release
    localparam logic [15:0] MAS_LOW_CYC = 16'((BIT_CYC >> 1) + (BIT_CYC >> 3));
    // Bit indices within a frame
    localparam logic [4:0] NB_CMD_LAST = 5'h07;
    localparam logic [4:0] NB_HOV = 5'h08;
    localparam logic [4:0] NB_WR_LAST = 5'h17;
    localparam logic [4:0] NB_WR_END = 5'h18;
    localparam logic [4:0] NB_RX_END = 5'h11;
    // Command queue in the host
    localparam int CMD_W = 24;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RX = 3'b001,
        D_HND = 3'b010,
        D_TX = 3'b011,
        D_REL = 3'b100
    } aslp_dev_state_type;

    typedef enum logic [2:0] {
        H_PRE = 3'b000,
        H_IDLE = 3'b001,
        H_START = 3'b010,
        H_TXB = 3'b011,
        H_RX = 3'b100,
        H_MTKO = 3'b101,
        H_STOP = 3'b110
    } aslp_host_state_type;

    // A bit is one when its high time exceeds half the rise to rise period
    function automatic logic aslp_is_one(input logic [15:0] hi, input logic [15:0] per);
        return hi > (per >> 1);
    endfunction
endpackage

// File: testbench/angle_sensor_one_wire_programming_test.sv
// Purpose: both link ends face each other; entry write, read, write
// Assumes: short timeout and power-on counts set by parameter
// Notes: queue is filled during the host hold so frames run back to back
`timescale 1ns/100ps
module angle_sensor_one_wire_programming_test;
    import aslp_pkg::*;
    logic clk_sys, rst, cmd_valid, cmd_read, cmd_ready, h_rd_valid, h_to, to_seen;
    logic normal_run, cmd_mode, wr_valid, rd_req, d_to, h_busy, sensor_out;
    logic [15:0] sensor_word;
    logic [6:0] cmd_addr, wr_addr, rd_addr;
    logic [15:0] cmd_data, h_rd_data, wr_data;
    int miscompares, checks;
    aslp_link_if link_i();
    aslp_host #(.TIMEOUT_CYC(16'h03E8)) aslp_host_i (.clk_sys(clk_sys), .rst(rst),
        .link(link_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_valid(h_rd_valid),
        .rd_data(h_rd_data), .busy(h_busy), .link_timeout(h_to));
    aslp_dev #(.TIMEOUT_CYC(16'h03E8), .TON_CYC(24'h00_7530), .ENTRY_CYC(24'h00_C350))
        aslp_dev_i (.clk_sys(clk_sys), .rst(rst), .link(link_i), .norm_out(sensor_out),
        .rd_data(sensor_word), .normal_run(normal_run), .cmd_mode(cmd_mode),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
        .rd_addr(rd_addr), .link_timeout(d_to));
    aslp_link_chk #(.TIMEOUT_CYC(16'h03E8)) aslp_link_chk_i (.clk_sys(clk_sys),
        .rst(rst), .host_o(link_i.host_o), .host_oe(link_i.host_oe),
        .dev_o(link_i.dev_o), .dev_oe(link_i.dev_oe), .line(link_i.line));
    // Clock at 40 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Sticky record of any timeout pulse; none is expected in clean frames
    always @(posedge clk_sys)
        to_seen <= rst ? 1'b0 : (to_seen | h_to | d_to);
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic ev(input int w);
        return (w == 0) ? wr_valid : ((w == 1) ? rd_req : h_rd_valid);
    endfunction
    // Pulses last one cycle, so every cycle is looked at once
    task automatic wait_ev(input int w);
        int n;
        for (n = 0; n < 40000; n++)
        begin
            @(posedge clk_sys);
            #1;
            if (ev(w) === 1'b1)
                break;
        end
        if (n == 40000)
        begin
            miscompares++;
            end_sim();
        end
    endtask
    // Leaves valid high so pushes can run back to back
    task automatic push(input logic rd, input logic [6:0] a, input logic [15:0] d);
        int n;
        cmd_read <= rd;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'b1;
        for (n = 0; n < 2000; n++)
        begin
            #1;
            if (cmd_ready === 1'b1)
                break;
            @(posedge clk_sys);
        end
        if (n == 2000)
        begin
            miscompares++;
            end_sim();
        end
        @(posedge clk_sys);
    endtask
    // Main sequence
    initial
    begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_read = 1'b0;
        cmd_addr = 7'h00;
        cmd_data = 16'h0000;
        sensor_out = 1'b0;
        sensor_word = 16'hA5C3;
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        push(1'b0, 7'h2A, 16'h1234);
        push(1'b1, 7'h15, 16'h0000);
        push(1'b0, 7'h33, 16'hBEEF);
        cmd_valid <= 1'b0;
        // Normal output must be high before entry, the idle level of the line
        sensor_out <= 1'b1;
        #1;
        check("mode before entry", {15'h0000, cmd_mode}, 16'h0000);
        check("host busy", {15'h0000, h_busy}, 16'h0001);
        check("sensor out", {15'h0000, link_i.dev_o}, 16'h0000);
        wait_ev(0);
        check("entry addr", {9'h000, wr_addr}, 16'h002A);
        check("entry data", wr_data, 16'h1234);
        check("mode entered", {15'h0000, cmd_mode}, 16'h0001);
        check("normal run", {15'h0000, normal_run}, 16'h0000);
        wait_ev(1);
        check("read addr", {9'h000, rd_addr}, 16'h0015);
        wait_ev(2);
        check("read word", h_rd_data, 16'hA5C3);
        check("sensor oe", {15'h0000, link_i.dev_oe}, 16'h0000);
        wait_ev(0);
        check("write addr", {9'h000, wr_addr}, 16'h0033);
        check("write data", wr_data, 16'hBEEF);
        check("mode kept", {15'h0000, cmd_mode}, 16'h0001);
        check("no timeout", {15'h0000, to_seen}, 16'h0000);
        end_sim();
    end
endmodule

// File: testbench/aslp_link_sva.sv
// Purpose: wire checks on the shared programming line
// Assumes: one clock, synchronous active high reset
// Notes: high run counter saturates so a long idle cannot wrap
`timescale 1ns/100ps
module aslp_link_chk
import aslp_pkg::*;
#(
    parameter logic [15:0] TIMEOUT_CYC = TO_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic line
);
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic [15:0] rel_q;
    // Run lengths of low and high on the wire
    always_ff @(posedge clk_sys)
    begin
        lo_q <= (rst || line) ? 16'h0000 : lo_q + 16'h0001;
        hi_q <= (rst || !line) ? 16'h0000 : hi_q + {15'h0000, hi_q != 16'hFFFF};
    end
    // Cycles since reset release, stops at the hold length
    always_ff @(posedge clk_sys)
    begin
        rel_q <= rst ? 16'h0000 : rel_q + {15'h0000, rel_q != TIMEOUT_CYC};
    end
    chk_reset_host: assert property (@(posedge clk_sys) rst |=> host_oe && host_o)
        else $error("host not driving high after reset");
    chk_reset_dev: assert property (@(posedge clk_sys) rst |=> dev_oe && !dev_o)
        else $error("sensor buffer not enabled low in reset");
    chk_hold_high: assert property (@(posedge clk_sys) disable iff (rst)
        rel_q < TIMEOUT_CYC |-> line) else $error("line fell during initial hold");
    chk_start_low: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(line) |-> lo_q >= ZERO_CYC - 16'h0005) else $error("low phase too short");
    chk_low_max: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(line) |-> lo_q <= BIT_CYC) else $error("low phase beyond a bit period");
    chk_high_min: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(line) |-> hi_q >= ZERO_CYC - 16'h0005) else $error("high phase too short");
    chk_slave_take: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(host_oe) && !$past(host_o) |-> dev_oe && !dev_o)
        else $error("sensor not holding low at host release");
    chk_master_take: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(dev_oe) && !$past(dev_o) && !$past(rst) |-> host_oe && !host_o)
        else $error("host not holding low at sensor release");
    chk_slave_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(dev_oe) |-> !line && !dev_o) else $error("sensor took an idle line");
endmodule
